// *** acl_dual_action_merge.sv ***
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
module acl_dual_action_merge
	import acl_merge_pkg::*;
(
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst,
	// register bus, write address
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
	input  wire logic [2:0]          s_axi_awprot,
	// register bus, write data
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	input  wire logic [AXI_DW-1:0]   s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	// register bus, write response
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	output logic      [1:0]          s_axi_bresp,
	// register bus, read address
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	input  wire logic [AXI_AW-1:0]   s_axi_araddr,
	input  wire logic [2:0]          s_axi_arprot,
	// register bus, read data
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	output logic      [AXI_DW-1:0]   s_axi_rdata,
	output logic      [1:0]          s_axi_rresp,
	// frame from the lookup stages
	input  wire logic                in_valid,
	input  wire logic                hit_first,
	input  wire logic                hit_second,
	input  wire logic [PORT_W-1:0]   in_dest_set,
	// action of the earlier lookup
	input  wire logic [MODE_W-1:0]   first_mask_mode,
	input  wire logic [PORT_W-1:0]   first_port_mask,
	input  wire logic [PROBE_W-1:0]  first_copy_monitor_select,
	input  wire logic [LOGINT_W-1:0] first_message_logging_interval,
	input  wire logic                first_l4_port_rewrite_enable,
	input  wire logic [L4_W-1:0]     first_l4_port_value,
	input  wire logic [REWCMD_W-1:0] first_rewriter_command,
	input  wire logic                first_hop_limit_decrement_enable,
	input  wire logic                first_sequence_number_tag_enable,
	input  wire logic [RTMODE_W-1:0] first_routing_rewrite_mode,
	input  wire logic [MAC_W-1:0]    first_replacement_mac_value,
	input  wire logic [TAG_W-1:0]    first_match_tag_value,
	input  wire logic [TAG_W-1:0]    first_match_tag_bitmask,
	input  wire logic [CIDX_W-1:0]   first_hit_counter_index,
	// action of the later lookup
	input  wire logic [MODE_W-1:0]   second_mask_mode,
	input  wire logic [PORT_W-1:0]   second_port_mask,
	input  wire logic [PROBE_W-1:0]  second_copy_monitor_select,
	input  wire logic [LOGINT_W-1:0] second_message_logging_interval,
	input  wire logic                second_l4_port_rewrite_enable,
	input  wire logic [L4_W-1:0]     second_l4_port_value,
	input  wire logic [REWCMD_W-1:0] second_rewriter_command,
	input  wire logic                second_hop_limit_decrement_enable,
	input  wire logic                second_sequence_number_tag_enable,
	input  wire logic [RTMODE_W-1:0] second_routing_rewrite_mode,
	input  wire logic [MAC_W-1:0]    second_replacement_mac_value,
	input  wire logic [TAG_W-1:0]    second_match_tag_value,
	input  wire logic [TAG_W-1:0]    second_match_tag_bitmask,
	input  wire logic [CIDX_W-1:0]   second_hit_counter_index,
	// merged action
	output logic                     out_valid,
	output logic      [MODE_W-1:0]   out_mask_mode,
	output logic      [PORT_W-1:0]   out_dest_set,
	output logic      [PROBE_W-1:0]  out_copy_monitor_select,
	output logic      [LOGINT_W-1:0] out_message_logging_interval,
	output logic                     out_l4_port_rewrite_enable,
	output logic      [L4_W-1:0]     out_l4_port_value,
	output logic      [REWCMD_W-1:0] out_rewriter_command,
	output logic                     out_hop_limit_decrement_enable,
	output logic                     out_sequence_number_tag_enable,
	output logic      [RTMODE_W-1:0] out_routing_rewrite_mode,
	output logic      [MAC_W-1:0]    out_replacement_mac_value,
	output logic      [TAG_W-1:0]    out_match_tag_value,
	output logic      [TAG_W-1:0]    out_match_tag_bitmask
);

	// sticky forwarding mask modes
	function automatic logic is_sticky(input logic [MODE_W-1:0] mode);
		return mode == MODE_REPLACE_ALL || mode == MODE_REDIRECT_TO_PORT_GROUP
			|| mode == MODE_STACKING_HEADER_FORWARD;
	endfunction : is_sticky

	// one forwarding mask step on the destination set
	function automatic logic [PORT_W-1:0] apply_mask(
		input logic [MODE_W-1:0] mode,
		input logic [PORT_W-1:0] mask,
		input logic [PORT_W-1:0] dest);
		logic [PORT_W-1:0] res;
		res = dest;
		unique case (mode)
			MODE_AND_MASK:                res = dest & mask;
			MODE_OR_MASK:                 res = dest | mask;
			MODE_REPLACE_ALL:             res = mask;
			MODE_REDIRECT_TO_PORT_GROUP:  res = mask;
			MODE_AND_NOT_MASK:            res = dest & ~mask;
			MODE_STACKING_HEADER_FORWARD: res = mask;
			default:                      res = dest;
		endcase
		return res;
	endfunction : apply_mask

	// one match tag step: masked bits replaced by the action's value
	function automatic logic [TAG_W-1:0] apply_tag(
		input logic [TAG_W-1:0] val,
		input logic [TAG_W-1:0] mask,
		input logic [TAG_W-1:0] prev);
		return (prev & ~mask) | (val & mask);
	endfunction : apply_tag

	logic [AXI_DW-1:0] ctrl;
	logic [AXI_DW-1:0] merged_frames;
	logic [CIDX_W-1:0] cnt_sel;
	logic [CNT_W-1:0]  cnt_rd_data;
	logic              count_en;

	// effective actions: a lone hit becomes the first action
	logic                a_use_first;
	logic                b_valid;
	logic [MODE_W-1:0]   a_mode;
	logic [PORT_W-1:0]   a_mask;
	logic [PROBE_W-1:0]  a_probe;
	logic [LOGINT_W-1:0] a_logint;
	logic                a_l4_en;
	logic [L4_W-1:0]     a_l4_val;
	logic [REWCMD_W-1:0] a_rew;
	logic                a_hop;
	logic                a_seq;
	logic [RTMODE_W-1:0] a_rt;
	logic [MAC_W-1:0]    a_mac;
	logic [TAG_W-1:0]    a_tag;
	logic [TAG_W-1:0]    a_tag_mask;
	logic [CIDX_W-1:0]   a_cidx;

	assign a_use_first = hit_first;
	assign b_valid     = hit_first && hit_second;
	assign a_mode      = a_use_first ? first_mask_mode : second_mask_mode;
	assign a_mask      = a_use_first ? first_port_mask : second_port_mask;
	assign a_probe     = a_use_first ? first_copy_monitor_select : second_copy_monitor_select;
	assign a_logint    = a_use_first ? first_message_logging_interval
		: second_message_logging_interval;
	assign a_l4_en     = a_use_first ? first_l4_port_rewrite_enable
		: second_l4_port_rewrite_enable;
	assign a_l4_val    = a_use_first ? first_l4_port_value : second_l4_port_value;
	assign a_rew       = a_use_first ? first_rewriter_command : second_rewriter_command;
	assign a_hop       = a_use_first ? first_hop_limit_decrement_enable
		: second_hop_limit_decrement_enable;
	assign a_seq       = a_use_first ? first_sequence_number_tag_enable
		: second_sequence_number_tag_enable;
	assign a_rt        = a_use_first ? first_routing_rewrite_mode : second_routing_rewrite_mode;
	assign a_mac       = a_use_first ? first_replacement_mac_value
		: second_replacement_mac_value;
	assign a_tag       = a_use_first ? first_match_tag_value : second_match_tag_value;
	assign a_tag_mask  = a_use_first ? first_match_tag_bitmask : second_match_tag_bitmask;
	assign a_cidx      = a_use_first ? first_hit_counter_index : second_hit_counter_index;

	// merge of the two actions
	logic [MODE_W-1:0]   next_mode;
	logic [PORT_W-1:0]   next_dest;
	logic [PROBE_W-1:0]  next_probe;
	logic [LOGINT_W-1:0] next_logint;
	logic                next_l4_en;
	logic [L4_W-1:0]     next_l4_val;
	logic [REWCMD_W-1:0] next_rew;
	logic                next_hop;
	logic                next_seq;
	logic [RTMODE_W-1:0] next_rt;
	logic [MAC_W-1:0]    next_mac;
	logic [TAG_W-1:0]    next_tag;
	logic [TAG_W-1:0]    next_tag_mask;

	always_comb
	begin
		logic [PORT_W-1:0] dest_a;
		dest_a = apply_mask(a_mode, a_mask, in_dest_set);
		next_mode   = a_mode;
		next_dest   = dest_a;
		next_probe  = a_probe;
		next_logint = a_logint;
		next_l4_en  = a_l4_en;
		next_l4_val = a_l4_val;
		next_rew    = a_rew;
		next_hop    = a_hop;
		next_seq    = a_seq;
		next_rt     = a_rt;
		next_mac    = a_mac;
		next_tag    = apply_tag(a_tag, a_tag_mask, '0);
		next_tag_mask = a_tag_mask;
		if (b_valid)
		begin
			// second mask step starts from the first result unless sticky
			if (!is_sticky(a_mode))
			begin
				next_dest = apply_mask(second_mask_mode, second_port_mask, dest_a);
				if (second_mask_mode != MODE_KEEP)
					next_mode = second_mask_mode;
			end
			if (second_copy_monitor_select > '0)
				next_probe = second_copy_monitor_select;
			if (second_message_logging_interval > '0)
				next_logint = second_message_logging_interval;
			if (second_l4_port_rewrite_enable)
			begin
				next_l4_en  = 1'b1;
				next_l4_val = second_l4_port_value;
			end
			// functions of both actions combine; shared ones take the second's
			next_rew = a_rew | second_rewriter_command;
			next_hop = a_hop | second_hop_limit_decrement_enable;
			next_seq = a_seq | second_sequence_number_tag_enable;
			next_rt  = a_rt | second_routing_rewrite_mode;
			if (second_routing_rewrite_mode != '0)
				next_mac = second_replacement_mac_value;
			next_tag = apply_tag(second_match_tag_value, second_match_tag_bitmask,
				next_tag);
			next_tag_mask = a_tag_mask | second_match_tag_bitmask;
		end
	end

	// merged action register
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			out_valid                      <= 1'b0;
			out_mask_mode                  <= MODE_KEEP;
			out_dest_set                   <= '0;
			out_copy_monitor_select        <= '0;
			out_message_logging_interval   <= '0;
			out_l4_port_rewrite_enable     <= 1'b0;
			out_l4_port_value              <= '0;
			out_rewriter_command           <= '0;
			out_hop_limit_decrement_enable <= 1'b0;
			out_sequence_number_tag_enable <= 1'b0;
			out_routing_rewrite_mode       <= '0;
			out_replacement_mac_value      <= '0;
			out_match_tag_value            <= '0;
			out_match_tag_bitmask          <= '0;
		end
		else
		begin
			out_valid <= in_valid && (hit_first || hit_second);
			if (in_valid && (hit_first || hit_second))
			begin
				out_mask_mode                  <= next_mode;
				out_dest_set                   <= next_dest;
				out_copy_monitor_select        <= next_probe;
				out_message_logging_interval   <= next_logint;
				out_l4_port_rewrite_enable     <= next_l4_en;
				out_l4_port_value              <= next_l4_val;
				out_rewriter_command           <= next_rew;
				out_hop_limit_decrement_enable <= next_hop;
				out_sequence_number_tag_enable <= next_seq;
				out_routing_rewrite_mode       <= next_rt;
				out_replacement_mac_value      <= next_mac;
				out_match_tag_value            <= next_tag;
				out_match_tag_bitmask          <= next_tag_mask;
			end
		end
	end

	// hit counters, one per hitting action
	assign count_en = ctrl[CTRL_COUNT_EN_BIT];

	hit_counter_bank u_counters (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.inc_a       (in_valid && count_en && (hit_first || hit_second)),
		.inc_a_index (a_cidx),
		.inc_b       (in_valid && count_en && b_valid),
		.inc_b_index (second_hit_counter_index),
		.rd_index    (cnt_sel),
		.rd_data     (cnt_rd_data)
	);

	// count of frames that hit both lookups
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			merged_frames <= '0;
		else if (in_valid && b_valid)
			merged_frames <= merged_frames + 32'h00000001;
	end

	// write channel: address and data taken in either order
	logic              aw_held;
	logic              w_held;
	logic [AXI_AW-1:0] aw_addr;
	logic [AXI_DW-1:0] w_data;
	logic [3:0]        w_strb;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= '0;
			w_strb        <= '0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held       <= 1'b1;
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held       <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (aw_held && w_held && !s_axi_bvalid)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr == REG_CTRL || aw_addr == REG_CNT_SEL
					|| aw_addr == REG_STATUS || aw_addr == REG_CNT_DATA)
					? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// writable registers; status and counter data ignore writes
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl    <= CTRL_RESET;
			cnt_sel <= '0;
		end
		else if (aw_held && w_held && !s_axi_bvalid)
		begin
			if (aw_addr == REG_CTRL && w_strb[0])
				ctrl <= w_data & CTRL_RESET;
			if (aw_addr == REG_CNT_SEL && w_strb[0])
				cnt_sel <= w_data[CIDX_W-1:0];
		end
	end

	// read channel: answer one cycle after the address is taken
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= RESP_OKAY;
				unique case (s_axi_araddr)
					REG_CTRL:     s_axi_rdata <= ctrl;
					REG_STATUS:   s_axi_rdata <= merged_frames;
					REG_CNT_SEL:  s_axi_rdata <= {{(AXI_DW-CIDX_W){1'b0}}, cnt_sel};
					REG_CNT_DATA: s_axi_rdata <= cnt_rd_data;
					default:
					begin
						s_axi_rdata <= '0;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end
			if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule : acl_dual_action_merge

// *** acl_dual_action_merge_bench.sv ***
module acl_dual_action_merge_bench
	import acl_merge_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// driven inputs start at zero, except rst, s_axi_wstrb and in_dest_set
	bit                  ref_clk, in_valid, hit_first, hit_second;
	bit                  rst = 1'b1;
	bit                  s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	bit [AXI_AW-1:0]     s_axi_awaddr, s_axi_araddr;
	bit [2:0]            s_axi_awprot, s_axi_arprot;
	bit [AXI_DW-1:0]     s_axi_wdata;
	bit [3:0]            s_axi_wstrb = 4'hF;
	bit [PORT_W-1:0]     in_dest_set = 11'h0F0;
	bit [PORT_W-1:0]     first_port_mask, second_port_mask;
	bit [MODE_W-1:0]     first_mask_mode, second_mask_mode;
	bit [PROBE_W-1:0]    first_copy_monitor_select, second_copy_monitor_select;
	bit [LOGINT_W-1:0]   first_message_logging_interval, second_message_logging_interval;
	bit                  first_l4_port_rewrite_enable, second_l4_port_rewrite_enable;
	bit [L4_W-1:0]       first_l4_port_value, second_l4_port_value;
	bit [REWCMD_W-1:0]   first_rewriter_command, second_rewriter_command;
	bit                  first_hop_limit_decrement_enable, second_hop_limit_decrement_enable;
	bit                  first_sequence_number_tag_enable, second_sequence_number_tag_enable;
	bit [RTMODE_W-1:0]   first_routing_rewrite_mode, second_routing_rewrite_mode;
	bit [MAC_W-1:0]      first_replacement_mac_value, second_replacement_mac_value;
	bit [TAG_W-1:0]      first_match_tag_value, second_match_tag_value;
	bit [TAG_W-1:0]      first_match_tag_bitmask, second_match_tag_bitmask;
	bit [CIDX_W-1:0]     first_hit_counter_index, second_hit_counter_index;
	// design outputs and captured answers
	logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]          s_axi_bresp, s_axi_rresp, resp;
	logic [AXI_DW-1:0]   s_axi_rdata, rd;
	logic                out_valid, out_l4_port_rewrite_enable;
	logic                out_hop_limit_decrement_enable, out_sequence_number_tag_enable;
	logic [MODE_W-1:0]   out_mask_mode;
	logic [PORT_W-1:0]   out_dest_set;
	logic [PROBE_W-1:0]  out_copy_monitor_select;
	logic [LOGINT_W-1:0] out_message_logging_interval;
	logic [L4_W-1:0]     out_l4_port_value;
	logic [REWCMD_W-1:0] out_rewriter_command;
	logic [RTMODE_W-1:0] out_routing_rewrite_mode;
	logic [MAC_W-1:0]    out_replacement_mac_value;
	logic [TAG_W-1:0]    out_match_tag_value, out_match_tag_bitmask;
	logic [15:0]         frames_seen;
	int                  fail_count, compares, i, n;
	// one merge case: hits, modes, masks, probes, intervals, commands
	typedef struct {
		logic h1, h2;
		logic [2:0] m1, m2, em;
		logic [10:0] k1, k2, ed;
		logic [1:0] p1, p2, ep;
		logic [3:0] l1, l2, el;
		logic [7:0] r1, r2, er;
	} row_t;
	row_t rows [6] = '{
		'{1'b1,1'b1,3'h4,3'h1,3'h4,11'h00F,11'h7FF,11'h00F,2'h1,2'h0,2'h1,4'h5,4'h0,4'h5,8'h01,8'h02,8'h03},
		'{1'b1,1'b1,3'h6,3'h2,3'h6,11'h155,11'h001,11'h155,2'h1,2'h2,2'h2,4'h5,4'h9,4'h9,8'h03,8'h01,8'h03},
		'{1'b1,1'b1,3'h3,3'h5,3'h3,11'h0F0,11'h030,11'h0F0,2'h3,2'h0,2'h3,4'h0,4'h0,4'h0,8'h81,8'h81,8'h81},
		'{1'b1,1'b1,3'h1,3'h2,3'h2,11'h0C0,11'h001,11'h0C1,2'h0,2'h3,2'h3,4'h0,4'hF,4'hF,8'h00,8'h80,8'h80},
		'{1'b0,1'b1,3'h4,3'h1,3'h1,11'h7FF,11'h00F,11'h000,2'h3,2'h1,2'h1,4'h2,4'h7,4'h7,8'h10,8'h04,8'h04},
		'{1'b1,1'b0,3'h5,3'h6,3'h5,11'h030,11'h7FF,11'h0C0,2'h3,2'h1,2'h3,4'h1,4'h8,4'h1,8'h20,8'h40,8'h20}
	};

	acl_dual_action_merge u_acl_dual_action_merge (.*);
	merge_sink u_merge_sink (.*);

	// free-running clock, 50 ns period
	initial
	begin
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic close_out();
		if (fail_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	// one register access; each channel released once taken
	task automatic axi(input logic wr, input logic [AXI_AW-1:0] a, input logic [AXI_DW-1:0] d);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		for (n = 0; n < 40; n++)
		begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (wr ? s_axi_bvalid : s_axi_rvalid)
			begin
				s_axi_bready <= 1'b0;
				s_axi_rready <= 1'b0;
				resp = wr ? s_axi_bresp : s_axi_rresp;
				rd = s_axi_rdata;
				return;
			end
		end
		fail_count++;
		close_out();
	endtask : axi

	// present one frame at the next edge
	task automatic frame(input logic h1, input logic h2);
		@(posedge ref_clk);
		hit_first <= h1;
		hit_second <= h2;
		in_valid <= 1'b1;
	endtask : frame

	// main sequence
	initial
	begin
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		#1;
		check("valid", out_valid, 1'b0);
		@(posedge ref_clk);
		axi(1'b0, REG_CTRL, 32'h0);
		check("ctrl", rd, CTRL_RESET);
		for (i = 0; i < 6; i++)
		begin
			frame(rows[i].h1, rows[i].h2);
			first_mask_mode <= rows[i].m1;
			second_mask_mode <= rows[i].m2;
			first_port_mask <= rows[i].k1;
			second_port_mask <= rows[i].k2;
			first_copy_monitor_select <= rows[i].p1;
			second_copy_monitor_select <= rows[i].p2;
			first_message_logging_interval <= rows[i].l1;
			second_message_logging_interval <= rows[i].l2;
			first_rewriter_command <= rows[i].r1;
			second_rewriter_command <= rows[i].r2;
			@(posedge ref_clk);
			in_valid <= 1'b0;
			#1;
			check("valid", out_valid, 1'b1);
			check("mode", out_mask_mode, rows[i].em);
			check("dest", out_dest_set, rows[i].ed);
			check("probe", out_copy_monitor_select, rows[i].ep);
			check("log", out_message_logging_interval, rows[i].el);
			check("rew", out_rewriter_command, rows[i].er);
		end
		// reset again mid-run, then back-to-back frames and a refused one
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		first_hit_counter_index <= 7'h05;
		second_hit_counter_index <= 7'h05;
		first_l4_port_rewrite_enable <= 1'b1;
		first_l4_port_value <= 16'h1111;
		second_l4_port_value <= 16'h2222;
		first_hop_limit_decrement_enable <= 1'b1;
		second_sequence_number_tag_enable <= 1'b1;
		first_routing_rewrite_mode <= 4'h1;
		second_routing_rewrite_mode <= 4'h2;
		first_replacement_mac_value <= 48'h111111111111;
		second_replacement_mac_value <= 48'hAAAAAAAAAAAA;
		first_match_tag_value <= 8'hA5;
		first_match_tag_bitmask <= 8'hF0;
		second_match_tag_value <= 8'h0F;
		second_match_tag_bitmask <= 8'h0F;
		#1;
		check("dest", out_dest_set, 11'h000);
		frame(1'b1, 1'b1);
		frame(1'b1, 1'b1);
		second_l4_port_rewrite_enable <= 1'b1;
		#1;
		check("valid", out_valid, 1'b1);
		check("l4", out_l4_port_value, 16'h1111);
		frame(1'b0, 1'b0);
		#1;
		check("valid", out_valid, 1'b1);
		@(posedge ref_clk);
		in_valid <= 1'b0;
		#1;
		check("valid", out_valid, 1'b0);
		check("l4", out_l4_port_value, 16'h2222);
		check("l4en", out_l4_port_rewrite_enable, 1'b1);
		check("hop", out_hop_limit_decrement_enable, 1'b1);
		check("seq", out_sequence_number_tag_enable, 1'b1);
		check("route", out_routing_rewrite_mode, 4'h3);
		check("mac", out_replacement_mac_value, 48'hAAAAAAAAAAAA);
		check("tag", out_match_tag_value, 8'hAF);
		check("tagmask", out_match_tag_bitmask, 8'hFF);
		check("sink", frames_seen, 16'h0002);
		// counters, status and an unmapped address
		@(posedge ref_clk);
		axi(1'b1, REG_CNT_SEL, 32'h5);
		check("bresp", resp, RESP_OKAY);
		repeat (2) @(posedge ref_clk);
		axi(1'b0, REG_CNT_DATA, 32'h0);
		check("count", rd, 32'h4);
		@(posedge ref_clk);
		axi(1'b0, REG_STATUS, 32'h0);
		check("status", rd, 32'h2);
		@(posedge ref_clk);
		axi(1'b0, 8'h10, 32'h0);
		check("resp", resp, RESP_SLVERR);
		check("rdata", rd, 32'h0);
		close_out();
	end
endmodule : acl_dual_action_merge_bench

// *** acl_dual_action_merge_properties.sv ***
module acl_merge_checker
	import acl_merge_pkg::*;
(
	// clock and reset
	input wire logic                ref_clk,
	input wire logic                rst,
	// frame and action fields
	input wire logic                in_valid,
	input wire logic                hit_first,
	input wire logic                hit_second,
	input wire logic [MODE_W-1:0]   first_mask_mode,
	input wire logic [PROBE_W-1:0]  first_copy_monitor_select,
	input wire logic [PROBE_W-1:0]  second_copy_monitor_select,
	input wire logic [LOGINT_W-1:0] first_message_logging_interval,
	input wire logic [LOGINT_W-1:0] second_message_logging_interval,
	input wire logic [REWCMD_W-1:0] first_rewriter_command,
	input wire logic [REWCMD_W-1:0] second_rewriter_command,
	// merged result
	input wire logic                out_valid,
	input wire logic [MODE_W-1:0]   out_mask_mode,
	input wire logic [PROBE_W-1:0]  out_copy_monitor_select,
	input wire logic [LOGINT_W-1:0] out_message_logging_interval,
	input wire logic [REWCMD_W-1:0] out_rewriter_command
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// frame taken, and frame hitting both lookups
	sequence s_take;
		in_valid && (hit_first || hit_second);
	endsequence
	sequence s_both;
		in_valid && hit_first && hit_second;
	endsequence
	property p_answer;
		s_take |=> out_valid;
	endproperty
	a_answer: assert property (p_answer) else $error("merged result missing");
	property p_idle;
		!(in_valid && (hit_first || hit_second)) |=> !out_valid;
	endproperty
	a_idle: assert property (p_idle) else $error("merged result without hit");
	property p_sticky;
		s_both ##0 first_mask_mode inside {3'h3, 3'h4, 3'h6}
			|=> out_mask_mode == $past(first_mask_mode);
	endproperty
	a_sticky: assert property (p_sticky) else $error("sticky mode lost");
	property p_probe;
		s_both |=> out_copy_monitor_select == (|$past(second_copy_monitor_select) ?
			$past(second_copy_monitor_select) : $past(first_copy_monitor_select));
	endproperty
	a_probe: assert property (p_probe) else $error("probe merge wrong");
	property p_log;
		s_both |=> out_message_logging_interval == (|$past(second_message_logging_interval) ?
			$past(second_message_logging_interval) : $past(first_message_logging_interval));
	endproperty
	a_log: assert property (p_log) else $error("interval merge wrong");
	property p_rew;
		s_both |=> out_rewriter_command ==
			($past(first_rewriter_command) | $past(second_rewriter_command));
	endproperty
	a_rew: assert property (p_rew) else $error("rewriter merge wrong");
	property p_only_second;
		in_valid && !hit_first && hit_second
			|=> out_message_logging_interval == $past(second_message_logging_interval);
	endproperty
	a_only_second: assert property (p_only_second) else $error("single hit altered");
	property p_only_first;
		in_valid && hit_first && !hit_second
			|=> out_rewriter_command == $past(first_rewriter_command);
	endproperty
	a_only_first: assert property (p_only_first) else $error("single hit altered");
endmodule : acl_merge_checker

bind acl_dual_action_merge acl_merge_checker u_acl_merge_checker (.*);

// *** acl_merge_pkg.sv ***
package acl_merge_pkg;

	// field widths of one action
	localparam int PORT_W   = 11;
	localparam int MODE_W   = 3;
	localparam int PROBE_W  = 2;
	localparam int LOGINT_W = 4;
	localparam int L4_W     = 16;
	localparam int REWCMD_W = 8;
	localparam int RTMODE_W = 4;
	localparam int MAC_W    = 48;
	localparam int TAG_W    = 8;
	localparam int CIDX_W   = 7;
	localparam int CNT_W    = 32;
	localparam int CNT_DEPTH = 128;

	// forwarding mask modes
	localparam logic [MODE_W-1:0] MODE_KEEP              = 3'h0;
	localparam logic [MODE_W-1:0] MODE_AND_MASK          = 3'h1;
	localparam logic [MODE_W-1:0] MODE_OR_MASK           = 3'h2;
	localparam logic [MODE_W-1:0] MODE_REPLACE_ALL       = 3'h3;
	localparam logic [MODE_W-1:0] MODE_REDIRECT_TO_PORT_GROUP = 3'h4;
	localparam logic [MODE_W-1:0] MODE_AND_NOT_MASK      = 3'h5;
	localparam logic [MODE_W-1:0] MODE_STACKING_HEADER_FORWARD = 3'h6;

	// register bus
	localparam int AXI_AW = 8;
	localparam int AXI_DW = 32;
	localparam logic [AXI_AW-1:0] REG_CTRL     = 8'h00;
	localparam logic [AXI_AW-1:0] REG_STATUS   = 8'h04;
	localparam logic [AXI_AW-1:0] REG_CNT_SEL  = 8'h08;
	localparam logic [AXI_AW-1:0] REG_CNT_DATA = 8'h0C;
	localparam logic [AXI_DW-1:0] CTRL_RESET   = 32'h00000001;
	localparam int CTRL_COUNT_EN_BIT = 0;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : acl_merge_pkg

// *** hit_counter_bank.sv ***
module hit_counter_bank
	import acl_merge_pkg::*;
(
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst,
	// increment requests, one per action
	input  wire logic              inc_a,
	input  wire logic [CIDX_W-1:0] inc_a_index,
	input  wire logic              inc_b,
	input  wire logic [CIDX_W-1:0] inc_b_index,
	// read port
	input  wire logic [CIDX_W-1:0] rd_index,
	output logic      [CNT_W-1:0]  rd_data
);

	logic [CNT_W-1:0] count_mem [CNT_DEPTH];
	logic             same_index;

	// both actions on one index add two to that entry
	assign same_index = inc_b && inc_a_index == inc_b_index;

	// counter array update
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < CNT_DEPTH; i++)
				count_mem[i] <= '0;
		end
		else
		begin
			if (inc_a)
				count_mem[inc_a_index] <= count_mem[inc_a_index]
					+ {{(CNT_W-2){1'b0}}, same_index, !same_index};
			if (inc_b && !(inc_a && same_index))
				count_mem[inc_b_index] <= count_mem[inc_b_index] + 32'h00000001;
		end
	end

	// registered read
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			rd_data <= '0;
		else
			rd_data <= count_mem[rd_index];
	end

endmodule : hit_counter_bank

// *** merge_sink.sv ***
module merge_sink
(
	// clock and reset
	input wire logic   ref_clk,
	input wire logic   rst,
	// merged result strobe
	input wire logic   out_valid,
	// results accepted downstream
	output logic [15:0] frames_seen
);
	timeunit 1ns;
	timeprecision 1ns;
	// count every merged result handed on
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			frames_seen <= 16'h0000;
		else if (out_valid)
			frames_seen <= frames_seen + 16'h0001;
	end
endmodule : merge_sink
